// *** hw/rts_insert.sv ***
// Receive path: event qualification, timestamp insertion, checksum handling, gap control
// Behaviour
// - Hold 4-bit minimum gap in byte times, reset twelve; drop preamble to keep it.
// - Appended timestamp may eat up to 134 byte times of the following gap.
// - Discard timestamp on UDP checksum error unless keep-on-UDP-error is set.
// - Discard timestamp on frame CRC error unless keep-on-CRC-error is set.
// - Insertion enable writes stamp into event packets and withholds it from readout.
// - Layer-2 append control adds stamp after message; ignored without insertion.
// - With domain matching, capture only when domain number equals the domain field.
// - Insertion on IPv4 without fixup zeroes UDP checksum; bad checksum forces CRC error.
// - With fixup, keep checksum and write 2-byte correction after message.
// - Seconds enable adds a seconds field; otherwise only nanoseconds are inserted.
// - Seconds length selects one to four low-order seconds bytes.
// - Nanoseconds position counts from message end in append, else from message start.
// - Seconds position counts from nanoseconds end in append, else from message start.
// - Capture timestamps only while the capture enable is set.
`timescale 1ns/1ns
`default_nettype none
module rts_insert #(
	parameter int unsigned DEPTH = 256,
	parameter int unsigned HOLD  = 4
) (
	input  wire logic                  clk_i,
	input  wire logic                  resetn_i,
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [9:0]            paddr_i,
	input  wire logic [31:0]           pwdata_i,
	output logic      [31:0]           prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	input  wire logic                  link_clk_i,
	input  wire logic                  link_dv_i,
	input  wire logic [7:0]            link_data_i,
	input  wire logic                  meta_valid_i,
	input  wire rts_pkg::rts_meta_t    meta_i,
	input  wire rts_pkg::rts_stamp_t   stamp_i,
	input  wire logic                  udp_err_i,
	input  wire logic                  crc_err_i,
	output logic                       mac_stb_o,
	output logic                       mac_dv_o,
	output logic      [7:0]            mac_data_o,
	output logic                       mac_err_o
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam logic [AW:0] PTR_ONE = {{AW{1'b0}}, 1'b1};
	localparam logic [AW:0] HOLD_W  = (AW + 1)'(HOLD);

	if (HOLD < 3 || HOLD >= DEPTH) begin : g_bad_hold
		$error("rts_insert: HOLD must be at least 3 and below DEPTH");
	end

	typedef struct packed {
		logic                  lclk_s1, lclk_s2, lclk_prev, dv_s1, dv_s2;
		logic [7:0]            dat_s1, dat_s2;
		logic                  w_dv_prev;
		logic [AW:0]           wr_ptr, rd_ptr;
		logic [1:0]            pri;
		logic [15:0]           gd, lay;
		rts_pkg::rts_meta_t    meta, r_meta;
		rts_pkg::rts_stamp_t   stamp, r_stamp;
		logic                  udp_l, crc_l, r_qual;
		rts_pkg::rts_rd_state_t st;
		logic [3:0]            gap, drop, ogap;
		logic [rts_pkg::POS_W-1:0] pos;
		logic [7:0]            app_k;
		logic [15:0]           diff;
		logic                  mac_dv, mac_err, mac_stb;
		logic [7:0]            mac_data;
		logic [31:0]           ro_ns, ro_sec, prdata;
		logic                  ro_avail;
	} rts_state_t;

	rts_state_t q, d;
	logic                        stb, wr_en, consume, ro_load, mark, ins, app, sec_on, forced, in_ns, in_sec;
	logic [rts_pkg::WORD_W-1:0]  wr_word, rd_word;
	logic [AW:0]                 cnt;
	logic [rts_pkg::POS_W-1:0]   rel, relns, relss, nsp11, ssp11;
	logic [5:0]                  nsp, ssp;
	logic [2:0]                  nsec;
	logic [7:0]                  a0, a1, a2, total, ab, ob, ib;
	logic [3:0]                  mingap, newgap;
	logic [15:0]                 fix_v, nw, ow;
	logic [7:0]                  idx;

	function automatic logic [7:0] msb_byte(input logic [31:0] v, input logic [2:0] n, input logic [7:0] i);
		logic [7:0] j;
		j = {5'h00, n} - 8'h01 - i;
		return v[{j[1:0], 3'b000} +: 8];
	endfunction : msb_byte

	function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[15:0] + {15'h0000, s[16]};
	endfunction : oc_add

	rts_ring_mem #(.WIDTH(rts_pkg::WORD_W), .DEPTH(DEPTH)) u_ring (
		.clk_i    (clk_i),
		.wr_en_i  (wr_en),
		.wr_addr_i(q.wr_ptr[AW-1:0]),
		.wr_data_i(wr_word),
		.rd_addr_i(q.rd_ptr[AW-1:0]),
		.rd_data_o(rd_word)
	);

	always_comb begin
		d = q;
		// Link pins pass two flops; edge found on the second stage only
		d.lclk_s1 = link_clk_i;
		d.lclk_s2 = q.lclk_s1;
		d.lclk_prev = q.lclk_s2;
		d.dv_s1 = link_dv_i;
		d.dv_s2 = q.dv_s1;
		d.dat_s1 = link_data_i;
		d.dat_s2 = q.dat_s1;
		stb = q.lclk_s2 & ~q.lclk_prev;
		d.mac_stb = stb;
		d.mac_err = 1'b0;

		// Writer: bytes and an end marker carrying the frame's error status
		wr_en = 1'b0;
		wr_word = {1'b0, q.dat_s2};
		if (stb) begin
			d.w_dv_prev = q.dv_s2;
			if (q.dv_s2) begin
				wr_en = 1'b1;
				if (!q.w_dv_prev) begin
					d.udp_l = 1'b0;
					d.crc_l = 1'b0;
				end
			end else if (q.w_dv_prev) begin
				wr_en = 1'b1;
				wr_word = {1'b1, 6'h00, q.udp_l | udp_err_i, q.crc_l | crc_err_i};
			end
		end
		if (wr_en) begin
			d.wr_ptr = q.wr_ptr + PTR_ONE;
		end
		// Error pulses win over the clear at frame start
		if (udp_err_i) begin
			d.udp_l = 1'b1;
		end
		if (crc_err_i) begin
			d.crc_l = 1'b1;
		end
		if (meta_valid_i) begin
			d.meta = meta_i;
			d.stamp = stamp_i;
		end

		// Register bus
		idx = paddr_i[9:2];
		if (psel_i && penable_i && pwrite_i && paddr_i[1:0] == 2'h0) begin
			unique case (idx)
				rts_pkg::IDX_PRIMARY:    d.pri = pwdata_i[1:0];
				rts_pkg::IDX_GAP_DOMAIN: d.gd = pwdata_i[15:0];
				rts_pkg::IDX_LAYOUT:     d.lay = pwdata_i[15:0];
				default:                 d.pri = q.pri;
			endcase
		end
		// Reading the seconds word consumes the readout; a new capture wins
		if (psel_i && penable_i && !pwrite_i && paddr_i == {rts_pkg::IDX_RO_SEC, 2'b00}) begin
			d.ro_avail = 1'b0;
		end
		if (psel_i && !penable_i) begin
			unique case (idx)
				rts_pkg::IDX_PRIMARY:    d.prdata = {30'h00000000, q.pri};
				rts_pkg::IDX_GAP_DOMAIN: d.prdata = {16'h0000, q.gd};
				rts_pkg::IDX_LAYOUT:     d.prdata = {16'h0000, q.lay};
				rts_pkg::IDX_RO_NS:      d.prdata = q.ro_ns;
				rts_pkg::IDX_RO_SEC:     d.prdata = q.ro_sec;
				rts_pkg::IDX_RO_STAT:    d.prdata = {31'h00000000, q.ro_avail};
				default:                 d.prdata = 32'h00000000;
			endcase
		end

		// Insertion layout
		cnt = q.wr_ptr - q.rd_ptr;
		mark = rd_word[8];
		mingap = q.gd[rts_pkg::GD_MIN_GAP_LSB +: 4];
		ins = q.r_qual & q.gd[rts_pkg::GD_INSERT];
		app = ins & q.r_meta.is_l2 & q.gd[rts_pkg::GD_APPEND];
		sec_on = q.lay[rts_pkg::LAY_SEC_EN];
		nsec = {1'b0, q.lay[rts_pkg::LAY_SEC_LEN_LSB +: 2]} + 3'h1;
		nsp = q.lay[rts_pkg::LAY_NS_POS_LSB +: 6];
		ssp = q.lay[rts_pkg::LAY_SEC_POS_LSB +: 6];
		a0 = {2'b00, nsp};
		a1 = a0 + 8'h04;
		a2 = a1 + {2'b00, ssp};
		total = sec_on ? a2 + {5'h00, nsec} : a1;
		if (q.app_k < a0 || (q.app_k >= a1 && q.app_k < a2)) begin
			ab = 8'h00;
		end else if (q.app_k < a1) begin
			ab = msb_byte(q.r_stamp.ns, 3'h4, q.app_k - a0);
		end else begin
			ab = msb_byte(q.r_stamp.sec, nsec, q.app_k - a2);
		end
		rel = q.pos - q.r_meta.msg_start;
		nsp11 = {5'h00, nsp};
		ssp11 = {5'h00, ssp};
		relns = rel - nsp11;
		relss = rel - ssp11;
		in_ns = ins && !app && rel >= nsp11 && rel < nsp11 + 11'h004;
		in_sec = ins && !app && sec_on && rel >= ssp11 && rel < ssp11 + {8'h00, nsec};
		ib = rd_word[7:0];
		ob = ib;
		if (in_ns) begin
			ob = msb_byte(q.r_stamp.ns, 3'h4, relns[7:0]);
		end
		if (in_sec) begin
			ob = msb_byte(q.r_stamp.sec, nsec, relss[7:0]);
		end
		nw = rel[0] ? {8'h00, ob} : {ob, 8'h00};
		ow = rel[0] ? {8'h00, ib} : {ib, 8'h00};
		// correction word, spoiled when the incoming checksum was bad
		fix_v = q.udp_l ? q.diff : ~q.diff;
		if (ins && q.r_meta.is_ipv4) begin
			if (!q.lay[rts_pkg::LAY_FIXUP]) begin
				if (q.pos == q.r_meta.csum_pos || q.pos == q.r_meta.csum_pos + 11'h001) begin
					ob = 8'h00;
				end
			end else if (rel == q.r_meta.msg_len) begin
				ob = fix_v[15:8];
			end else if (rel == q.r_meta.msg_len + 11'h001) begin
				ob = fix_v[7:0];
			end
		end
		forced = ins & q.r_meta.is_ipv4 & ~q.lay[rts_pkg::LAY_FIXUP] & rd_word[1];
		ro_load = 1'b0;
		consume = 1'b0;
		newgap = (q.gap == rts_pkg::GAP_SAT) ? q.gap : q.gap + 4'h1;

		unique case (q.st)
			rts_pkg::RTS_IDLE: begin
				if (stb) begin
					d.gap = newgap;
					// Wait for a few bytes so that late status is known before it is needed
					if (cnt >= HOLD_W) begin
						d.st = rts_pkg::RTS_RUN;
						d.pos = '0;
						d.diff = 16'h0000;
						d.r_meta = q.meta;
						d.r_stamp = q.stamp;
						d.r_qual = q.pri[rts_pkg::PRI_CAPTURE] & q.meta.is_event &
							(~q.pri[rts_pkg::PRI_DOMAIN_MATCH] | (q.meta.domain == q.gd[rts_pkg::GD_DOMAIN_LSB +: 8]));
						d.drop = (newgap < mingap) ? mingap - newgap : 4'h0;
					end
				end
			end
			rts_pkg::RTS_RUN: begin
				if (stb && cnt != '0) begin
					consume = 1'b1;
					d.rd_ptr = q.rd_ptr + PTR_ONE;
					if (mark) begin
						d.mac_dv = 1'b0;
						d.mac_err = rd_word[0] | forced;
						ro_load = q.r_qual & ~q.gd[rts_pkg::GD_INSERT] &
							(~rd_word[1] | q.gd[rts_pkg::GD_KEEP_UDP]) & (~rd_word[0] | q.gd[rts_pkg::GD_KEEP_CRC]);
						d.st = rts_pkg::RTS_IDLE;
						d.gap = 4'h1;
					end else if (q.drop != 4'h0) begin
						d.drop = q.drop - 4'h1;
						d.mac_dv = 1'b0;
						d.pos = q.pos + 11'h001;
					end else begin
						d.mac_dv = 1'b1;
						d.mac_data = ob;
						d.pos = q.pos + 11'h001;
						if (in_ns || in_sec) begin
							d.diff = oc_add(oc_add(q.diff, nw), ~ow);
						end
						if (app && rel == q.r_meta.msg_len - 11'h001) begin
							d.st = rts_pkg::RTS_APPEND;
							d.app_k = 8'h00;
						end
					end
				end
			end
			rts_pkg::RTS_APPEND: begin
				if (stb) begin
					d.mac_dv = 1'b1;
					d.mac_data = ab;
					d.app_k = q.app_k + 8'h01;
					if (q.app_k == total - 8'h01) begin
						d.st = rts_pkg::RTS_RUN;
					end
				end
			end
			default: d.st = rts_pkg::RTS_IDLE;
		endcase
		if (ro_load) begin
			d.ro_ns = q.r_stamp.ns;
			d.ro_sec = q.r_stamp.sec;
			d.ro_avail = 1'b1;
		end
		// Idle byte times seen by the MAC, for checking only
		if (stb) begin
			if (d.mac_dv) begin
				d.ogap = 4'h0;
			end else if (q.ogap != rts_pkg::GAP_SAT) begin
				d.ogap = q.ogap + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			q <= '0;
			q.pri <= rts_pkg::RST_PRIMARY;
			q.gd <= rts_pkg::RST_GAP_DOMAIN;
			q.lay <= rts_pkg::RST_LAYOUT;
			q.gap <= rts_pkg::GAP_SAT;
			q.ogap <= rts_pkg::GAP_SAT;
		end else begin
			q <= d;
		end
	end

	assign prdata_o = q.prdata;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & (paddr_i[1:0] != 2'h0 ||
		!(idx inside {rts_pkg::IDX_PRIMARY, rts_pkg::IDX_GAP_DOMAIN, rts_pkg::IDX_LAYOUT,
		rts_pkg::IDX_RO_NS, rts_pkg::IDX_RO_SEC, rts_pkg::IDX_RO_STAT}));
	assign mac_stb_o = q.mac_stb;
	assign mac_dv_o = q.mac_dv;
	assign mac_data_o = q.mac_data;
	assign mac_err_o = q.mac_err;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	gap_min_a: assert property ($rose(q.mac_dv) |-> $past(q.ogap) >= $past(mingap))
		else $error("gap to MAC below minimum");
	ro_insert_a: assert property ($rose(q.ro_avail) |-> !$past(q.gd[rts_pkg::GD_INSERT]))
		else $error("readout loaded while insertion on");
	udp_keep_a: assert property (ro_load |-> (!rd_word[1] || q.gd[rts_pkg::GD_KEEP_UDP]) ##1 q.ro_avail)
		else $error("stamp kept despite UDP error");
	crc_keep_a: assert property (ro_load |=> q.ro_ns == $past(q.r_stamp.ns) &&
		($past(!rd_word[0]) || $past(q.gd[rts_pkg::GD_KEEP_CRC])))
		else $error("stamp kept despite CRC error");
	domain_match_a: assert property (ro_load |-> (!q.pri[rts_pkg::PRI_DOMAIN_MATCH] ||
		q.r_meta.domain == q.gd[rts_pkg::GD_DOMAIN_LSB +: 8]) && q.r_qual)
		else $error("domain mismatch captured");
	capture_en_a: assert property ($rose(q.r_qual) |-> $past(q.pri[rts_pkg::PRI_CAPTURE]))
		else $error("capture while disabled");
	pass_thru_a: assert property (consume && !mark && q.drop == 4'h0 && !ins |=>
		q.mac_dv && q.mac_data == $past(rd_word[7:0]))
		else $error("byte altered without insertion");
	append_gate_a: assert property (q.st == rts_pkg::RTS_APPEND |-> q.gd[rts_pkg::GD_INSERT] &&
		q.r_meta.is_l2 && q.app_k < total)
		else $error("append without insertion");
	crc_force_a: assert property (consume && mark && forced |=> q.mac_err && !q.mac_dv)
		else $error("bad UDP checksum not forced to CRC error");

	cover property (ro_load);
	cover property (q.st == rts_pkg::RTS_APPEND ##1 q.st == rts_pkg::RTS_RUN);
	cover property (consume && q.drop != 4'h0);
	cover property (q.mac_err);
endmodule : rts_insert
`default_nettype wire

// *** hw/rts_pkg.sv ***
// Shared constants and types for the receive timestamp insertion block
package rts_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_PRIMARY    = 8'h18;
	localparam logic [7:0] IDX_GAP_DOMAIN = 8'h1C;
	localparam logic [7:0] IDX_LAYOUT     = 8'h1D;
	localparam logic [7:0] IDX_RO_NS      = 8'h20;
	localparam logic [7:0] IDX_RO_SEC     = 8'h21;
	localparam logic [7:0] IDX_RO_STAT    = 8'h22;

	// Primary configuration fields
	localparam int unsigned PRI_CAPTURE      = 0;
	localparam int unsigned PRI_DOMAIN_MATCH = 1;

	// Gap and domain register fields
	localparam int unsigned GD_MIN_GAP_LSB = 12;
	localparam int unsigned GD_KEEP_UDP    = 11;
	localparam int unsigned GD_KEEP_CRC    = 10;
	localparam int unsigned GD_APPEND      = 9;
	localparam int unsigned GD_INSERT      = 8;
	localparam int unsigned GD_DOMAIN_LSB  = 0;

	// Insert layout register fields
	localparam int unsigned LAY_FIXUP       = 15;
	localparam int unsigned LAY_SEC_EN      = 14;
	localparam int unsigned LAY_SEC_LEN_LSB = 12;
	localparam int unsigned LAY_NS_POS_LSB  = 6;
	localparam int unsigned LAY_SEC_POS_LSB = 0;

	// Reset values
	localparam logic [1:0]  RST_PRIMARY    = 2'h0;
	localparam logic [15:0] RST_GAP_DOMAIN = 16'hC000;
	localparam logic [15:0] RST_LAYOUT     = 16'h0000;
	localparam logic [3:0]  GAP_SAT        = 4'hF;

	localparam int unsigned POS_W  = 11;
	localparam int unsigned WORD_W = 9;

	typedef struct packed {
		logic             is_event;
		logic             is_ipv4;
		logic             is_l2;
		logic [7:0]       domain;
		logic [POS_W-1:0] msg_start;
		logic [POS_W-1:0] msg_len;
		logic [POS_W-1:0] csum_pos;
	} rts_meta_t;

	typedef struct packed {
		logic [31:0] sec;
		logic [31:0] ns;
	} rts_stamp_t;

	typedef enum logic [1:0] {
		RTS_IDLE   = 2'b00,
		RTS_RUN    = 2'b01,
		RTS_APPEND = 2'b10
	} rts_rd_state_t;

endpackage : rts_pkg

// *** hw/rts_ring_mem.sv ***
// Byte ring memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module rts_ring_mem #(
	parameter int unsigned WIDTH = 9,
	parameter int unsigned DEPTH = 256
) (
	input  wire logic                     clk_i,
	input  wire logic                     wr_en_i,
	input  wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
	input  wire logic [WIDTH-1:0]         wr_data_i,
	input  wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
	output logic      [WIDTH-1:0]         rd_data_o
);
	logic [WIDTH-1:0] mem_q [DEPTH];

	if (DEPTH < 8 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("rts_ring_mem: DEPTH must be a power of two of at least 8");
	end

	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem_q[wr_addr_i] <= wr_data_i;
		end
		rd_data_o <= mem_q[rd_addr_i];
	end
endmodule : rts_ring_mem
`default_nettype wire

// *** sim/rts_link_src.sv ***
// Receive link source model: line-side frames with side-band qualification
`timescale 1ns/1ns
`default_nettype none
module rts_link_src (
	input  wire logic           clk_i,
	output logic                link_clk_o,
	output logic                link_dv_o,
	output logic [7:0]          link_data_o,
	output logic                meta_valid_o,
	output rts_pkg::rts_meta_t  meta_o,
	output rts_pkg::rts_stamp_t stamp_o,
	output logic                udp_err_o,
	output logic                crc_err_o
);
	logic [7:0] frm [0:63];
	initial begin
		link_clk_o = 1'b0;
		link_dv_o = 1'b0;
		link_data_o = 8'h00;
		meta_valid_o = 1'b0;
		meta_o = '0;
		stamp_o = '0;
		udp_err_o = 1'b0;
		crc_err_o = 1'b0;
	end
	// Clock runs over a frame and its idle tail only; released data keeps toggling
	task automatic send(input int len, input rts_pkg::rts_meta_t m, input rts_pkg::rts_stamp_t s,
		input logic ue, input logic ce);
		for (int b = 0; b < len + 20; b++) begin
			@(posedge clk_i);
			link_clk_o <= 1'b0;
			link_dv_o <= (b < len);
			link_data_o <= (b < len) ? frm[b] : ~link_data_o;
			meta_valid_o <= (b == 1);
			meta_o <= m;
			stamp_o <= s;
			udp_err_o <= ue && (b == 2);
			crc_err_o <= ce && (b == 2);
			@(posedge clk_i);
			meta_valid_o <= 1'b0;
			udp_err_o <= 1'b0;
			crc_err_o <= 1'b0;
			repeat (3) @(posedge clk_i);
			link_clk_o <= 1'b1;
			repeat (3) @(posedge clk_i);
		end
	endtask : send
endmodule : rts_link_src
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the receive timestamp insertion block
`timescale 1ns/1ns
`default_nettype none
module testbench;
	localparam int         LEN    = 48;
	localparam int         MSG    = 14;
	localparam int         CSUM   = 12;
	localparam logic [9:0] A_PRI  = {rts_pkg::IDX_PRIMARY, 2'b00};
	localparam logic [9:0] A_GD   = {rts_pkg::IDX_GAP_DOMAIN, 2'b00};
	localparam logic [9:0] A_LAY  = {rts_pkg::IDX_LAYOUT, 2'b00};
	localparam logic [9:0] A_NS   = {rts_pkg::IDX_RO_NS, 2'b00};
	localparam logic [9:0] A_SEC  = {rts_pkg::IDX_RO_SEC, 2'b00};
	localparam logic [9:0] A_STAT = {rts_pkg::IDX_RO_STAT, 2'b00};
	logic                clk_i;
	logic                resetn_i;
	logic                psel_i;
	logic                penable_i;
	logic                pwrite_i;
	logic [9:0]          paddr_i;
	logic [31:0]         pwdata_i;
	logic [31:0]         prdata_o;
	logic                pready_o;
	logic                pslverr_o;
	logic                link_clk_i;
	logic                link_dv_i;
	logic [7:0]          link_data_i;
	logic                meta_valid_i;
	rts_pkg::rts_meta_t  meta_i;
	rts_pkg::rts_stamp_t stamp_i;
	logic                udp_err_i;
	logic                crc_err_i;
	logic                mac_stb_o;
	logic                mac_dv_o;
	logic [7:0]          mac_data_o;
	logic                mac_err_o;
	int                  n_mismatch = 0;
	int                  checks_done = 0;
	int                  seed = 32'h40E50640;
	int                  cycles = 0;
	logic [7:0]          exp_q [$];
	logic                app_on = 1'b0;
	logic                ok_st;
	logic [31:0]         exp_ns = 32'h00000000;
	logic [7:0]          got [$];
	logic                got_err = 1'b0;
	logic                in_frm = 1'b0;
	rts_pkg::rts_stamp_t stamp_q;
	logic [31:0]         rd;
	logic                er;
	logic [31:0]         r;
	int                  np;
	int                  sp;
	rts_insert rts_insert_i (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .link_clk_i(link_clk_i), .link_dv_i(link_dv_i), .link_data_i(link_data_i),
		.meta_valid_i(meta_valid_i), .meta_i(meta_i), .stamp_i(stamp_i), .udp_err_i(udp_err_i),
		.crc_err_i(crc_err_i), .mac_stb_o(mac_stb_o), .mac_dv_o(mac_dv_o), .mac_data_o(mac_data_o),
		.mac_err_o(mac_err_o));
	rts_link_src rts_link_src_i (.clk_i(clk_i), .link_clk_o(link_clk_i), .link_dv_o(link_dv_i),
		.link_data_o(link_data_i), .meta_valid_o(meta_valid_i), .meta_o(meta_i), .stamp_o(stamp_i),
		.udp_err_o(udp_err_i), .crc_err_o(crc_err_i));
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	task automatic print_verdict();
		if (n_mismatch == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	// Collects the bytes handed to the MAC; a hang ends in the verdict
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_mismatch++;
			print_verdict();
		end
		if (mac_stb_o === 1'b1) begin
			if (mac_dv_o === 1'b1)
				got.push_back(mac_data_o);
			else if (in_frm)
				got_err = mac_err_o;
			in_frm <= (mac_dv_o === 1'b1);
		end
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] wd, output logic [31:0] d,
		output logic e);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= wd;
		@(posedge clk_i);
		penable_i <= 1'b1;
		// Only the bench timeout ends a wait that never sees ready
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		d = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	task automatic wreg(input logic [9:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic e;
		apb(1'b1, a, d, x, e);
	endtask : wreg
	function automatic void mk_exp(input logic ins, input logic ap, input logic v4, input logic se,
		input logic [1:0] sl, input int p, input int q, input rts_pkg::rts_stamp_t s);
		int k;
		exp_q.delete();
		for (int i = 0; i < LEN; i++)
			exp_q.push_back(rts_link_src_i.frm[i]);
		k = LEN - 4;
		if (ins && ap) begin
			for (int i = 0; i < p + 4; i++) begin
				exp_q.insert(k, (i < p) ? 8'h00 : s.ns[31 - 8 * (i - p) -: 8]);
				k++;
			end
			for (int i = 0; se && i < q + sl + 1; i++) begin
				exp_q.insert(k, (i < q) ? 8'h00 : s.sec[8 * (sl + q - i) + 7 -: 8]);
				k++;
			end
		end else if (ins) begin
			for (int i = 0; i < 4; i++)
				exp_q[MSG + p + i] = s.ns[31 - 8 * i -: 8];
			for (int i = 0; se && i <= sl; i++)
				exp_q[MSG + q + i] = s.sec[8 * sl + 7 - 8 * i -: 8];
			if (v4) begin
				exp_q[CSUM] = 8'h00;
				exp_q[CSUM + 1] = 8'h00;
			end
		end
	endfunction : mk_exp
	task automatic run_frame(input logic ins, input logic v4, input logic ev, input logic [7:0] dom,
		input logic se, input logic [1:0] sl, input int p, input int q, input logic ue, input logic ce);
		rts_pkg::rts_meta_t m;
		for (int i = 0; i < LEN; i++)
			rts_link_src_i.frm[i] = 8'($random(seed));
		m = '{is_event: ev, is_ipv4: v4, is_l2: !v4, domain: dom, msg_start: 11'(MSG),
			msg_len: 11'(LEN - MSG - 4), csum_pos: 11'(CSUM)};
		stamp_q = {32'($random(seed)), 32'($random(seed))};
		mk_exp(ins & ev, app_on & !v4, v4, se, sl, p, q, stamp_q);
		got.delete();
		rts_link_src_i.send(LEN, m, stamp_q, ue, ce);
		chk("frame length", 32'(got.size()), 32'(exp_q.size()));
		for (int i = 0; i < exp_q.size(); i++)
			chk("frame byte", 32'(got[i]), 32'(exp_q[i]));
		chk("frame error", 32'(got_err), 32'(ce | (ins & ev & v4 & ue)));
	endtask : run_frame
	initial begin
		resetn_i = 1'b0;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 10'h000;
		pwdata_i = 32'h00000000;
		repeat (6) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		apb(1'b0, A_GD, 32'h0, rd, er);
		chk("gap reset", rd, 32'h0000C000);
		apb(1'b0, A_LAY, 32'h0, rd, er);
		chk("layout reset", rd, 32'h00000000);
		r = 32'($random(seed)) & 32'h00007FFF;
		wreg(A_LAY, r);
		apb(1'b0, A_LAY, 32'h0, rd, er);
		chk("layout readback", rd, r);
		apb(1'b0, 10'h3FC, 32'h0, rd, er);
		chk("unmapped error", 32'(er), 32'h1);
		chk("unmapped data", rd, 32'h0);
		wreg(A_LAY, 32'h00000000);
		wreg(A_GD, 32'h0000C000);
		run_frame(1'b0, 1'b0, 1'b1, 8'h00, 1'b0, 2'h0, 0, 0, 1'b0, 1'b1);
		wreg(A_PRI, 32'h00000001);
		for (int c = 0; c < 5; c++) begin
			np = $random(seed) & 3;
			sp = 8 + ($random(seed) & 7);
			wreg(A_GD, 32'h0000C100);
			wreg(A_LAY, {16'h0, 1'b0, 1'(c < 4), 2'(c), 6'(np), 6'(sp)});
			run_frame(1'b1, 1'b0, 1'b1, 8'h00, 1'(c < 4), 2'(c), np, sp, 1'b0, 1'b0);
			apb(1'b0, A_STAT, 32'h0, rd, er);
			chk("readout withheld", rd, 32'h0);
			apb(1'b0, A_SEC, 32'h0, rd, er);
		end
		wreg(A_LAY, 32'h00000000);
		run_frame(1'b1, 1'b1, 1'b1, 8'h00, 1'b0, 2'h0, 0, 0, 1'b1, 1'b0);
		// Bits: capture, event, crc, udp, domain miss, match on, keep crc, keep udp
		for (int k = 0; k < 16; k++) begin
			r = (k < 4) ? (32'h3 | (32'h4 << k)) : 32'($random(seed));
			wreg(A_PRI, {30'h0, r[5], r[0]});
			wreg(A_GD, {16'h0, 4'hC, r[7], r[6], 2'b00, 8'h5A});
			apb(1'b0, A_SEC, 32'h0, rd, er);
			run_frame(1'b0, 1'b0, r[1], r[4] ? 8'hA5 : 8'h5A, 1'b0, 2'h0, 0, 0, r[3], r[2]);
			apb(1'b0, A_STAT, 32'h0, rd, er);
			ok_st = r[0] & r[1] & (!r[5] | !r[4]) & (!r[2] | r[6]) & (!r[3] | r[7]);
			chk("stamp status", rd, 32'(ok_st));
			// A discarded stamp leaves the previous readout in place
			if (ok_st)
				exp_ns = stamp_q.ns;
			apb(1'b0, A_NS, 32'h0, rd, er);
			chk("stamp ns", rd, exp_ns);
		end
		// append after message; last, so the shortened gap meets no later frame
		app_on = 1'b1;
		np = $random(seed) & 1;
		sp = $random(seed) & 1;
		r = 32'($random(seed)) & 32'h00000003;
		wreg(A_PRI, 32'h00000001);
		wreg(A_GD, 32'h0000C300);
		wreg(A_LAY, {16'h0, 2'b01, 2'(r), 6'(np), 6'(sp)});
		run_frame(1'b1, 1'b0, 1'b1, 8'h00, 1'b1, 2'(r), np, sp, 1'b0, 1'b0);
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
